/* File: inc/lspf_pkg.sv */
// Purpose: Shared constants and types for the load switch and power-fail control block.
// Assumes: Core clock of 250 MHz; all analog indications arrive as raw comparator levels.
// Notes:   Switch index 0 is the low-voltage switch, 1 the reverse-blocking, 2 the medium-voltage.

package lspf_pkg;

    // Core clock period and switch count.
    localparam int LSPF_CLK_NS      = 4;
    localparam int LSPF_NUM_SW      = 3;
    localparam int LSPF_IDX_LOW     = 0;
    localparam int LSPF_IDX_REVB    = 1;
    localparam int LSPF_IDX_MEDV    = 2;

    // Timing figures in their own units and the cycle counts derived from them.
    localparam int LSPF_DIP_WINDOW_MS = 5;
    localparam int LSPF_PD_SETTLE_MS  = 500;
    localparam int LSPF_PU_EXTRA_MS   = 1;
    localparam int LSPF_NS_PER_MS     = 1000000;
    localparam int LSPF_DIP_CYCLES    = LSPF_DIP_WINDOW_MS * LSPF_NS_PER_MS / LSPF_CLK_NS;
    localparam int LSPF_PD_CYCLES     = LSPF_PD_SETTLE_MS * LSPF_NS_PER_MS / LSPF_CLK_NS;
    localparam int LSPF_PU_CYCLES     = LSPF_PU_EXTRA_MS * LSPF_NS_PER_MS / LSPF_CLK_NS;

    // Counter widths sized for the documented counts.
    localparam int LSPF_DIP_CNT_W   = 21;
    localparam int LSPF_PD_CNT_W    = 27;
    localparam int LSPF_PU_CNT_W    = 18;

    // Current limit values in milliamps, ascending with the two-bit select code.
    localparam int LSPF_MA_W        = 11;
    localparam logic [10:0] LSPF_RB_LIMIT0_MA = 11'h064;
    localparam logic [10:0] LSPF_RB_LIMIT1_MA = 11'h0C8;
    localparam logic [10:0] LSPF_RB_LIMIT2_MA = 11'h1F4;
    localparam logic [10:0] LSPF_RB_LIMIT3_MA = 11'h3E8;
    localparam logic [10:0] LSPF_MV_LIMIT0_MA = 11'h0FA;
    localparam logic [10:0] LSPF_MV_LIMIT1_MA = 11'h1F4;
    localparam logic [10:0] LSPF_MV_LIMIT2_MA = 11'h2EE;
    localparam logic [10:0] LSPF_MV_LIMIT3_MA = 11'h3E8;

    // Reset values: switches off, every discharge path pulling while the core is held in reset.
    localparam logic [2:0] LSPF_SW_RST   = 3'h0;
    localparam logic [2:0] LSPF_DCHG_RST = 3'h7;

    // Raw analog indications, all active high.
    typedef struct packed {
        logic       powerfail_sense_input;
        logic [2:0] ilim_active;
        logic [2:0] overtemp_shutdown;
        logic       revblock_in_uv;
        logic       bias_uvlo;
        logic       bias_below_fast_floor;
        logic       bias_below_slow_floor;
        logic       bias_above_hyst;
        logic       slow_rise_mode;
    } lspf_sense_type;

    localparam int LSPF_SENSE_W = $bits(lspf_sense_type);

    typedef enum logic [1:0] {
        PU_IDLE,
        PU_WAIT_GOOD,
        PU_EXTRA
    } lspf_pu_state_type;

    // Whole state of the control block.
    typedef struct packed {
        lspf_sense_type             s1;
        lspf_sense_type             s2;
        lspf_sense_type             s3;
        lspf_sense_type             flt;
        logic                       pf_prev;
        logic [2:0]                 shed;
        logic [2:0]                 sw_on;
        logic [2:0]                 dchg;
        logic [2:0]                 ilim_flag;
        logic [2:0]                 fault_flag;
        logic [10:0]                rb_ma;
        logic [10:0]                mv_ma;
        logic                       dip_active;
        logic [LSPF_DIP_CNT_W-1:0]  dip_cnt;
        logic                       pd_start;
        logic                       pd_busy;
        logic [LSPF_PD_CNT_W-1:0]   pd_cnt;
        logic                       off_state;
        lspf_pu_state_type          pu_state;
        logic [LSPF_PU_CNT_W-1:0]   pu_cnt;
        logic                       rail_enable;
    } lspf_state_type;

endpackage : lspf_pkg

/* File: verilog/lspf_ctrl.sv */
// Purpose: Control of the three current-limited load switches, power-fail shedding,
//          bias undervoltage handling and the power-down / power-up timing hooks.
// Assumes: Single 250 MHz core clock; rst is the core reset raised when bias collapses.
// Notes:   Host control bits arrive as plain levels on the core clock; analog levels are synchronised.

`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Each switch follows its own on bit, the low-voltage one only while the sequencer does not own it.
// - Low-voltage switch is driven by the sequencer or by the host.
// - Reverse-blocking and medium-voltage switches obey only the host.
// - Per-switch discharge, off after reset, grounds the output while the switch is off.
// - Power-fail trip turns off every switch whose shed bit is set.
// - A shed switch stays off until the host writes it on again.
// - Current limiting raises that switch's limit flag; the switch stays on.
// - Overtemperature forces a switch off; it returns by itself when cool.
// - Fault flag stands while overtemperature holds the switch off.
// - Reverse-blocking switch limits 100/200/500/1000 mA by two bits, own overcurrent flag.
// - Reverse-blocking switch off while its input is undervoltage, recovers automatically.
// - Reverse-blocking fault flag stands while input undervoltage holds it off.
// - Medium-voltage switch has four limits by its own two-bit field.
// - After reset a power-fail trip changes nothing unless shedding or shutdown is set.
// - With shutdown coupling set, a power-fail trip starts power-down.
// - The power-fail comparator state is not visible at any status output.
// - A bias undervoltage dip starts power-down once it crosses the floor or outlasts the 5 ms window.
// - Core reset switches everything off with all discharge paths on.
// - Fast-rise supply: dip above 2.55 V is tolerated if it recovers within 5 ms.
// - Slow-rise supply: dip above 2.5 V tolerated if above hysteresis within 5 ms.
// - A late rail delays the next enable until good, then 1 ms more.
// - Off state is entered 500 ms after power-down starts.
module lspf_ctrl
    import lspf_pkg::*;
#(
    parameter int                 DIP_CYC    = LSPF_DIP_CYCLES,
    parameter int                 PD_CYC     = LSPF_PD_CYCLES,
    parameter int                 PU_CYC     = LSPF_PU_CYCLES,
    parameter logic [10:0]        MV_LIMIT0  = LSPF_MV_LIMIT0_MA,
    parameter logic [10:0]        MV_LIMIT1  = LSPF_MV_LIMIT1_MA,
    parameter logic [10:0]        MV_LIMIT2  = LSPF_MV_LIMIT2_MA,
    parameter logic [10:0]        MV_LIMIT3  = LSPF_MV_LIMIT3_MA
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [2:0]       switch_on_bit,
    input  wire logic [2:0]       switch_on_write,
    input  wire logic             seq_owns_low,
    input  wire logic             seq_low_on,
    input  wire logic [2:0]       switch_discharge_enable,
    input  wire logic [2:0]       switch_powerfail_shed_enable,
    input  wire logic             powerfail_shutdown_enable,
    input  wire logic [1:0]       revblock_limit_select,
    input  wire logic [1:0]       medvolt_limit_select,
    input  wire logic             strobe_due,
    input  wire logic             prev_rail_good,
    input  wire lspf_sense_type   sense_in,
    output logic [2:0]            switch_gate,
    output logic [2:0]            switch_discharge_drive,
    output logic [2:0]            switch_current_limit_flag,
    output logic [2:0]            switch_fault_flag,
    output logic [10:0]           revblock_limit_ma,
    output logic [10:0]           medvolt_limit_ma,
    output logic                  powerdown_start,
    output logic                  powerdown_busy,
    output logic                  off_state,
    output logic                  next_rail_enable
);

    lspf_state_type st_q;
    lspf_state_type st_d;

    logic [2:0]              req;
    logic [2:0]              hold_off;
    logic                    pf_rise;
    logic                    dip_floor;
    logic                    dip_recov;
    logic                    dip_fail;
    logic                    pd_go;
    logic [LSPF_SENSE_W-1:0] s2_bits;
    logic [LSPF_SENSE_W-1:0] s3_bits;
    logic [LSPF_SENSE_W-1:0] flt_bits;

    // Picks one 11-bit limit out of four packed entries; entry 0 sits in the low bits.
    function automatic logic [10:0] lspf_limit_ma(input logic [1:0] sel, input logic [43:0] tbl);
        logic [10:0] val;
        val = 11'h000;
        case (sel)
            2'h0: val = tbl[10:0];
            2'h1: val = tbl[21:11];
            2'h2: val = tbl[32:22];
            default: val = tbl[43:33];
        endcase
        return val;
    endfunction : lspf_limit_ma

    // The low-voltage switch goes to the sequencer when it owns that rail; the others see only the host.
    assign req[LSPF_IDX_LOW]  = seq_owns_low ? seq_low_on : switch_on_bit[LSPF_IDX_LOW];
    assign req[LSPF_IDX_REVB] = switch_on_bit[LSPF_IDX_REVB];
    assign req[LSPF_IDX_MEDV] = switch_on_bit[LSPF_IDX_MEDV];

    // Local protection that forces a switch off and lets it return by itself.
    assign hold_off[LSPF_IDX_LOW]  = st_q.flt.overtemp_shutdown[LSPF_IDX_LOW];
    assign hold_off[LSPF_IDX_REVB] = st_q.flt.overtemp_shutdown[LSPF_IDX_REVB]
                                   | st_q.flt.revblock_in_uv;
    assign hold_off[LSPF_IDX_MEDV] = st_q.flt.overtemp_shutdown[LSPF_IDX_MEDV];

    // Edge of the filtered power-fail trip; only the edge couples into power-down.
    assign pf_rise = st_q.flt.powerfail_sense_input & ~st_q.pf_prev;

    // The floor and the recovery level both depend on how fast the bias supply rose.
    assign dip_floor = st_q.flt.slow_rise_mode ? st_q.flt.bias_below_slow_floor
                                               : st_q.flt.bias_below_fast_floor;
    assign dip_recov = st_q.flt.slow_rise_mode ? st_q.flt.bias_above_hyst
                                               : ~st_q.flt.bias_uvlo;

    // A dip fails when it crosses the floor or outlasts the window without recovering.
    assign dip_fail = st_q.dip_active ? (~dip_recov & (dip_floor
                                         | (st_q.dip_cnt == LSPF_DIP_CNT_W'(DIP_CYC - 1))))
                                      : (st_q.flt.bias_uvlo & dip_floor);

    // A second trigger while power-down runs, or in the off state, is ignored.
    assign pd_go = ~st_q.pd_busy & ~st_q.off_state
                 & ((pf_rise & powerfail_shutdown_enable) | dip_fail);

    // Raw sync stages and the filtered level seen as plain vectors for the agreement filter.
    assign s2_bits  = st_q.s2;
    assign s3_bits  = st_q.s3;
    assign flt_bits = st_q.flt;

    // Next state of the whole block.
    always_comb begin
        st_d = st_q;

        // Three-stage synchroniser; a level is taken once stages two and three agree.
        st_d.s1  = sense_in;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        st_d.flt = lspf_sense_type'((~(s2_bits ^ s3_bits) & s2_bits)
                                  | ((s2_bits ^ s3_bits) & flt_bits));
        st_d.pf_prev = st_q.flt.powerfail_sense_input;

        // Shedding latches while the trip stands; a host write of 1 clears it, but the trip wins.
        st_d.shed = ({3{st_q.flt.powerfail_sense_input}} & switch_powerfail_shed_enable)
                  | (st_q.shed & ~(switch_on_write & switch_on_bit));

        // Gate drive combines the request with shedding and local protection.
        st_d.sw_on = req & ~st_d.shed & ~hold_off;
        st_d.dchg  = switch_discharge_enable & ~st_d.sw_on;

        // Limit flags only mean something while the switch conducts; protection flags while held.
        st_d.ilim_flag  = st_q.flt.ilim_active & st_q.sw_on;
        st_d.fault_flag = hold_off & req;

        // Limit selection, ascending with the code.
        st_d.rb_ma = lspf_limit_ma(revblock_limit_select,
                                   {LSPF_RB_LIMIT3_MA, LSPF_RB_LIMIT2_MA,
                                    LSPF_RB_LIMIT1_MA, LSPF_RB_LIMIT0_MA});
        st_d.mv_ma = lspf_limit_ma(medvolt_limit_select,
                                   {MV_LIMIT3, MV_LIMIT2, MV_LIMIT1, MV_LIMIT0});

        // Bias dip tracking, dropped once power-down has been committed.
        if (pd_go || st_q.pd_busy || st_q.off_state) begin
            st_d.dip_active = 1'b0;
            st_d.dip_cnt    = '0;
        end else if (!st_q.dip_active) begin
            if (st_q.flt.bias_uvlo) begin
                st_d.dip_active = 1'b1;
                st_d.dip_cnt    = '0;
            end
        end else if (dip_recov) begin
            st_d.dip_active = 1'b0;
        end else begin
            st_d.dip_cnt = st_q.dip_cnt + LSPF_DIP_CNT_W'(1);
        end

        // Power-down runs a fixed settle time, whatever the strobe delays are.
        st_d.pd_start = pd_go;
        if (pd_go) begin
            st_d.pd_busy = 1'b1;
            st_d.pd_cnt  = '0;
        end else if (st_q.pd_busy) begin
            if (st_q.pd_cnt == LSPF_PD_CNT_W'(PD_CYC - 1)) begin
                st_d.pd_busy   = 1'b1 ^ 1'b1;
                st_d.off_state = 1'b1;
            end else begin
                st_d.pd_cnt = st_q.pd_cnt + LSPF_PD_CNT_W'(1);
            end
        end else if (strobe_due) begin
            st_d.off_state = 1'b0;
        end

        // Strobe gate: a late rail holds the next enable until good, then one extra wait.
        st_d.rail_enable = 1'b0;
        case (st_q.pu_state)
            PU_IDLE: begin
                if (strobe_due && prev_rail_good) begin
                    st_d.rail_enable = 1'b1;
                end else if (strobe_due) begin
                    st_d.pu_state = PU_WAIT_GOOD;
                end
            end
            PU_WAIT_GOOD: begin
                if (prev_rail_good) begin
                    st_d.pu_state = PU_EXTRA;
                    st_d.pu_cnt   = '0;
                end
            end
            PU_EXTRA: begin
                if (st_q.pu_cnt == LSPF_PU_CNT_W'(PU_CYC - 1)) begin
                    st_d.rail_enable = 1'b1;
                    st_d.pu_state    = PU_IDLE;
                end else begin
                    st_d.pu_cnt = st_q.pu_cnt + LSPF_PU_CNT_W'(1);
                end
            end
            default: begin
                st_d.pu_state = PU_IDLE;
            end
        endcase
    end

    // Core reset opens every switch and turns on every discharge path until released.
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q      <= '0;
            st_q.sw_on <= LSPF_SW_RST;
            st_q.dchg  <= LSPF_DCHG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state; the power-fail level itself is never exported.
    assign switch_gate               = st_q.sw_on;
    assign switch_discharge_drive    = st_q.dchg;
    assign switch_current_limit_flag = st_q.ilim_flag;
    assign switch_fault_flag         = st_q.fault_flag;
    assign revblock_limit_ma         = st_q.rb_ma;
    assign medvolt_limit_ma          = st_q.mv_ma;
    assign powerdown_start           = st_q.pd_start;
    assign powerdown_busy            = st_q.pd_busy;
    assign off_state                 = st_q.off_state;
    assign next_rail_enable          = st_q.rail_enable;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Each host-only switch must stay dark without its own on bit, whatever the sequencer asks.
    a_host_only_ctrl: assert property (!switch_on_bit[2] |=> !switch_gate[2])
        else $error("Medium-voltage switch conducted without its on bit.");
    a_host_only_revb: assert property (!switch_on_bit[1] |=> !switch_gate[1])
        else $error("Reverse-blocking switch conducted without its on bit.");
    a_seq_low_ctrl: assert property (seq_owns_low && !seq_low_on |=> !switch_gate[0])
        else $error("Low-voltage switch ignored the sequencer.");
    a_switch_follows: assert property (switch_on_bit[2] && !st_d.shed[2] && !hold_off[2]
                                       |=> switch_gate[2])
        else $error("Medium-voltage switch did not follow its on bit.");
    a_dchg_when_off: assert property ($fell(switch_gate[1]) && switch_discharge_enable[1]
                                      && $past(switch_discharge_enable[1]) |-> switch_discharge_drive[1])
        else $error("Discharge not applied to an enabled switch that turned off.");
    a_shed_turns_off: assert property ($rose(st_q.flt.powerfail_sense_input)
                                       && switch_powerfail_shed_enable[1] |=> !switch_gate[1] [*2])
        else $error("Shed-enabled switch stayed on after a power-fail trip.");
    a_shed_sticky: assert property (st_q.shed[1] && !(switch_on_write[1] && switch_on_bit[1])
                                    |=> st_q.shed[1] && !switch_gate[1])
        else $error("Shed switch came back without a host write.");
    a_ilim_flag: assert property (st_q.flt.ilim_active[1] && switch_gate[1]
                                  |=> switch_current_limit_flag[1])
        else $error("Current limit flag missing while limiting.");
    a_ots_fault: assert property (st_q.flt.overtemp_shutdown[0] && req[0]
                                  |=> !switch_gate[0] && switch_fault_flag[0])
        else $error("Overtemperature did not hold the switch off with fault.");
    a_uv_fault: assert property (st_q.flt.revblock_in_uv && switch_on_bit[1]
                                 |=> !switch_gate[1] && switch_fault_flag[1])
        else $error("Input undervoltage did not hold the reverse-blocking switch off.");
    a_rb_limit_map: assert property (revblock_limit_select == 2'h2 |=> revblock_limit_ma == LSPF_RB_LIMIT2_MA)
        else $error("Reverse-blocking limit decode wrong.");
    a_pf_no_effect: assert property (pf_rise && !powerfail_shutdown_enable && !dip_fail
                                     |=> !powerdown_start)
        else $error("Power-fail trip started power-down without coupling.");
    a_pf_shutdown: assert property (pf_rise && powerfail_shutdown_enable && !powerdown_busy
                                    && !off_state |=> powerdown_start ##1 powerdown_busy)
        else $error("Coupled power-fail trip did not start power-down.");
    a_dip_window: assert property ($rose(powerdown_start) && !$past(pf_rise && powerfail_shutdown_enable)
                                   |-> $past(dip_floor) || $past(st_q.dip_cnt) == LSPF_DIP_CNT_W'(DIP_CYC - 1))
        else $error("Dip ended the device before its window or floor.");
    a_pd_settle: assert property ($rose(off_state) |-> $past(st_q.pd_cnt) == LSPF_PD_CNT_W'(PD_CYC - 1))
        else $error("Off state not entered at the settle count.");
    a_pu_extra: assert property ($rose(next_rail_enable) && $past(st_q.pu_state) == PU_EXTRA
                                 |-> $past(st_q.pu_cnt) == LSPF_PU_CNT_W'(PU_CYC - 1))
        else $error("Late-rail extra wait has the wrong length.");
    a_sync_agree: assert property ($changed(st_q.flt) |-> $past(st_q.s2 == st_q.s3))
        else $error("Filtered level moved without stage agreement.");

    c_shed_event: cover property ($rose(st_q.shed[1]));
    c_pd_by_pf: cover property (pf_rise && powerfail_shutdown_enable ##1 powerdown_start);
    c_dip_recover: cover property (st_q.dip_active ##1 !st_q.dip_active && !powerdown_start);
    c_late_rail: cover property (st_q.pu_state == PU_EXTRA ##1 st_q.pu_state == PU_EXTRA);

endmodule : lspf_ctrl

`default_nettype wire

/* File: sim/lspf_far_model.sv */
// Purpose: Far-side model that packs the analog comparator levels.
// Assumes: Bias supply healthy; a supply dip is not modelled.
// Notes:   Levels change only when the bench asks for it.
`timescale 1ns/10ps
`default_nettype none
module lspf_far_model
    import lspf_pkg::*;
(
    input  wire logic       trip,
    input  wire logic [2:0] hot,
    input  wire logic [2:0] lim,
    input  wire logic       in_low,
    output var lspf_sense_type sense
);
    // Bias comparators stay quiet so no dip can start a power-down.
    assign sense = {trip, lim, hot, in_low, 5'h00};
endmodule : lspf_far_model
`default_nettype wire

/* File: sim/load_switch_powerfail_control_tb.sv */
// Purpose: Self-checking bench for the load switch control block.
// Assumes: Short counts; analog levels act within six cycles.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
`default_nettype none
module load_switch_powerfail_control_tb;
    import lspf_pkg::*;
    localparam int PD = 40;
    localparam int PU = 10;
    logic mclk = 0, rst = 1, trip = 0, sol = 0, slo = 0, pfs = 0, sd = 0, prg = 0, in_low = 0;
    logic [2:0] on = 0, wr = 0, dis = 0, shed = 0, hot = 0, lim = 0, gate, drv, ilf, flt;
    logic [1:0] rbs = 0, mvs = 0;
    logic [10:0] rbma, mvma;
    logic pds, pdb, offs, nre;
    lspf_sense_type sense;
    int errors = 0, tests_run = 0, cycles = 0;
    lspf_far_model lspf_far_model_inst (.trip(trip), .hot(hot), .lim(lim), .in_low(in_low), .sense(sense));
    lspf_ctrl #(.DIP_CYC(20), .PD_CYC(PD), .PU_CYC(PU)) lspf_ctrl_inst (
        .mclk(mclk), .rst(rst), .switch_on_bit(on), .switch_on_write(wr), .seq_owns_low(sol),
        .seq_low_on(slo), .switch_discharge_enable(dis), .switch_powerfail_shed_enable(shed),
        .powerfail_shutdown_enable(pfs), .revblock_limit_select(rbs), .medvolt_limit_select(mvs),
        .strobe_due(sd), .prev_rail_good(prg), .sense_in(sense), .switch_gate(gate),
        .switch_discharge_drive(drv), .switch_current_limit_flag(ilf), .switch_fault_flag(flt),
        .revblock_limit_ma(rbma), .medvolt_limit_ma(mvma), .powerdown_start(pds),
        .powerdown_busy(pdb), .off_state(offs), .next_rail_enable(nre));
    // Free-running 250 MHz core clock.
    initial begin
        forever #2 mclk = ~mclk;
    end
    // A hang is cut short well after the expected run of about 114 cycles.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("errors %0d of %0d checks", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // Host and sequencer ownership of the switches.
    task automatic t_ctrl;
        dis = 3'h5; on = 3'h7; cyc(1);
        chk("gate", gate, 3'h7);
        chk("drv", drv, 3'h0);
        on = 3'h2; cyc(1);
        chk("gate", gate, 3'h2);
        chk("drv", drv, 3'h5);
        on = 3'h7; sol = 1; cyc(1);
        chk("gate", gate, 3'h6);
        slo = 1; on = 3'h0; cyc(1);
        chk("gate", gate, 3'h1);
        sol = 0; cyc(1);
        chk("gate", gate, 3'h0);
    endtask : t_ctrl
    // Shedding, then the host re-enables the shed switch.
    task automatic t_shed;
        on = 3'h7; shed = 3'h2; cyc(1); trip = 1; cyc(6);
        chk("gate", gate, 3'h5);
        chk("pd", {pds, pdb, offs}, 3'h0);
        trip = 0; cyc(8);
        chk("gate", gate, 3'h5);
        wr = 3'h2; cyc(1); wr = 0; cyc(1);
        chk("gate", gate, 3'h7);
        shed = 0;
    endtask : t_shed
    // Overtemperature, input undervoltage and current limiting.
    task automatic t_prot;
        hot = 3'h1; cyc(6);
        chk("gate", gate, 3'h6);
        chk("fault", flt, 3'h1);
        hot = 0; in_low = 1; lim = 3'h4; cyc(6);
        chk("gate", gate, 3'h5);
        chk("fault", flt, 3'h2);
        chk("ilim", ilf, 3'h4);
        in_low = 0; lim = 3'h2; cyc(6);
        chk("gate", gate, 3'h7);
        chk("ilim", ilf, 3'h2);
        lim = 0;
    endtask : t_prot
    // Every limit code of both fields.
    task automatic t_lim;
        logic [10:0] rbx[4];
        logic [10:0] mvx[4];
        rbx = '{LSPF_RB_LIMIT0_MA, LSPF_RB_LIMIT1_MA, LSPF_RB_LIMIT2_MA, LSPF_RB_LIMIT3_MA};
        mvx = '{LSPF_MV_LIMIT0_MA, LSPF_MV_LIMIT1_MA, LSPF_MV_LIMIT2_MA, LSPF_MV_LIMIT3_MA};
        for (int i = 0; i < 4; i++) begin
            rbs = 2'(i); mvs = 2'(i); cyc(1);
            chk("rb_ma", rbma, rbx[i]);
            chk("mv_ma", mvma, mvx[i]);
        end
    endtask : t_lim
    // Trip with shutdown coupling, settle, then leave the off state.
    task automatic t_pd;
        pfs = 1; trip = 1;
        for (int k = 0; k < 10 && pds !== 1'b1; k++) cyc(1);
        chk("start", pds, 1'b1);
        chk("busy", pdb, 1'b1);
        cyc(PD - 1);
        chk("off", offs, 1'b0);
        cyc(1);
        chk("off", {offs, pdb}, 2'h2);
        trip = 0; prg = 1; sd = 1; cyc(1); sd = 0;
        chk("off", offs, 1'b0);
        chk("next", nre, 1'b1);
    endtask : t_pd
    // Late rail: the strobe waits for good, then the extra wait, then one enable pulse.
    task automatic t_rail;
        prg = 0; sd = 1; cyc(1); sd = 0;
        chk("next", nre, 1'b0);
        cyc(2); prg = 1; cyc(PU);
        chk("next", nre, 1'b0);
        cyc(1);
        chk("next", nre, 1'b1);
        cyc(1);
        chk("next", nre, 1'b0);
    endtask : t_rail
    // Main sequence: reset checks, then every scenario once.
    initial begin
        cyc(8);
        chk("rst_drv", drv, 3'h7);
        chk("rst_gate", gate, 3'h0);
        rst = 0; cyc(1);
        chk("drv", drv, 3'h0);
        t_ctrl();
        t_shed();
        t_prot();
        t_lim();
        t_pd();
        t_rail();
        report_and_stop();
    end
endmodule : load_switch_powerfail_control_tb
`default_nettype wire
